// ### src/pse_regs_pkg.sv
package pse_regs_pkg;
	localparam int NUM_CH = 4;
	// command codes
	localparam logic [7:0] CMD_DISC_FIRST = 8'h0C;
	localparam logic [7:0] CMD_DISC_LAST = 8'h0F;
	localparam logic [7:0] CMD_POWER_STATE = 8'h10;
	// reset and idle values
	localparam logic [7:0] DISC_RESET = 8'h00;
	localparam logic [3:0] POWER_FLAGS_RESET = 4'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;
	localparam logic [3:0] ASSIGN_RESET = 4'h0;
	// field positions
	localparam int CLASS_POS = 4;
	localparam int DET_POS = 0;
	localparam int PG_POS = 4;
	localparam int ON_POS = 0;
	// requested class codes
	localparam logic [3:0] CLS_UNKNOWN = 4'h0;
	localparam logic [3:0] CLS_3 = 4'h3;
	localparam logic [3:0] CLS_4 = 4'h4;
	localparam logic [3:0] CLS_RSVD_AS_0 = 4'h5;
	localparam logic [3:0] CLS_0 = 4'h6;
	localparam logic [3:0] CLS_5_SS = 4'h8;
	localparam logic [3:0] CLS_8_SS = 4'hB;
	localparam logic [3:0] CLS_4P_TYPE1 = 4'hC;
	localparam logic [3:0] CLS_5_DS = 4'hD;
	// detection codes
	localparam logic [3:0] DET_UNKNOWN = 4'h0;
	localparam logic [3:0] DET_VALID = 4'h4;
	localparam logic [3:0] DET_FET_FAULT = 4'hE;
	// class report deadline after classification
	localparam int REPORT_LIMIT_MS = 5;
	localparam int CLK_HZ = 40_000_000;
	localparam int REPORT_LIMIT_CYC = REPORT_LIMIT_MS * (CLK_HZ / 1000);
	localparam int WAIT_W = 18;
endpackage

// ### src/chan_link_if.sv
`timescale 1ns/10ps
interface chan_link_if;
	logic chan_on;
	logic det_load;
	logic [3:0] det_code;
	logic cls_load;
	logic cls_own;
	logic [3:0] cls_code;
	logic alloc_15w5;
	logic diag_single;
	logic [7:0] disc;
	logic [3:0] assigned;
	logic cls_event;
	modport ctrl (output chan_on, det_load, det_code, cls_load, cls_own, cls_code, alloc_15w5,
		diag_single, input disc, assigned, cls_event);
	modport chan (input chan_on, det_load, det_code, cls_load, cls_own, cls_code, alloc_15w5,
		diag_single, output disc, assigned, cls_event);
endinterface

// ### src/chan_discovery.sv
`timescale 1ns/10ps
module chan_discovery (
	input wire logic core_clk,
	input wire logic sys_rst,
	chan_link_if.chan link
);
	typedef struct packed {
		logic [3:0] cls;
		logic [3:0] det;
		logic [3:0] assigned;
		logic cls_event;
		logic on_prev;
	} chan_state_t;

	chan_state_t s_q;
	chan_state_t s_d;
	logic turn_on;
	logic turn_off;

	function automatic logic class4plus(input logic [3:0] c);
		class4plus = (c == pse_regs_pkg::CLS_4) || (c == pse_regs_pkg::CLS_5_DS) ||
			((c >= pse_regs_pkg::CLS_5_SS) && (c <= pse_regs_pkg::CLS_8_SS));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state
	assign turn_on = ~s_q.on_prev & link.chan_on;
	assign turn_off = s_q.on_prev & ~link.chan_on;

	always_comb
	begin
		s_d = s_q;
		s_d.on_prev = link.chan_on;
		s_d.cls_event = 1'b0;
		if (turn_off)
		begin
			s_d.cls = pse_regs_pkg::CLS_UNKNOWN;
			s_d.det = pse_regs_pkg::DET_UNKNOWN;
			s_d.assigned = pse_regs_pkg::ASSIGN_RESET;
		end
		if (link.det_load)
			s_d.det = link.det_code;
		if (link.cls_load)
		begin
			s_d.cls = link.cls_code;
			if (link.diag_single && (link.cls_code == pse_regs_pkg::CLS_8_SS))
				s_d.cls = pse_regs_pkg::CLS_5_DS;
			s_d.cls_event = link.cls_own;
		end
		if (turn_on)
		begin
			if (link.alloc_15w5 && class4plus(s_d.cls))
				s_d.cls = pse_regs_pkg::CLS_4P_TYPE1;
			if ((s_d.cls == pse_regs_pkg::CLS_0) || (s_d.cls == pse_regs_pkg::CLS_RSVD_AS_0))
				s_d.assigned = pse_regs_pkg::CLS_3;
			else
				s_d.assigned = s_d.cls;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign link.disc = {s_q.cls, s_q.det};
	assign link.assigned = s_q.assigned;
	assign link.cls_event = s_q.cls_event;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	off_clear_a: assert property ($fell(link.chan_on) && !link.det_load && !link.cls_load
		|=> link.disc == pse_regs_pkg::DISC_RESET) else $error("discovery not cleared");
	type1_limit_a: assert property ($rose(link.chan_on) && link.alloc_15w5 && !link.cls_load
		&& class4plus(link.disc[7:4]) |=> link.disc[7:4] == pse_regs_pkg::CLS_4P_TYPE1)
		else $error("class not limited");
	class0_assign_a: assert property ($rose(link.chan_on) && !link.cls_load
		&& link.disc[7:4] == pse_regs_pkg::CLS_0 |=> link.assigned == pse_regs_pkg::CLS_3)
		else $error("class 0 not assigned 3");
	diag_remap_a: assert property (link.cls_load && link.diag_single
		&& !(link.alloc_15w5 && link.chan_on) && link.cls_code == pse_regs_pkg::CLS_8_SS
		|=> link.disc[7:4] == pse_regs_pkg::CLS_5_DS) else $error("no dual remap");
	det_report_a: assert property (link.det_load
		|=> link.disc[3:0] == $past(link.det_code)) else $error("detection lost");
endmodule // chan_discovery

// ### src/pse_discovery_power_status_regs.sv
`timescale 1ns/10ps
module pse_discovery_power_status_regs #(
	parameter int REPORT_LIMIT_CYC = pse_regs_pkg::REPORT_LIMIT_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [3:0] chan_on,
	input wire logic [3:0] pg_below_thr,
	input wire logic [3:0] det_done,
	input wire logic [15:0] det_code,
	input wire logic [3:0] cls_done,
	input wire logic [15:0] cls_code,
	input wire logic [1:0] pair_single_sig,
	input wire logic [3:0] alloc_15w5,
	input wire logic [3:0] diag_mode,
	input wire logic [3:0] cls_enable,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic cmd_hit,
	output logic [3:0] class_done_event,
	output logic [15:0] assigned_class
);
	typedef struct packed {
		logic [3:0] power_good_flags;
		logic [3:0] channel_on_flags;
		logic [7:0] rd_data;
		logic rd_valid;
		logic cmd_hit;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;
	logic [7:0] disc_all [pse_regs_pkg::NUM_CH];
	logic [3:0] pg_ready;
	logic [7:0] power_byte;

	////////////////////////////////////////////////////////////////////////////////
	// per channel discovery
	for (genvar ch = 0; ch < pse_regs_pkg::NUM_CH; ch++)
	begin : gen_ch
		localparam int PARTNER = ch ^ 1;
		logic single_sig;
		chan_link_if link ();

		assign single_sig = pair_single_sig[ch / 2];
		assign link.chan_on = chan_on[ch];
		assign link.det_load = det_done[ch];
		assign link.det_code = det_code[ch * 4 +: 4];
		assign link.cls_load = cls_done[ch] | (single_sig & cls_done[PARTNER]);
		assign link.cls_code = (cls_done[ch] | ~single_sig) ? cls_code[ch * 4 +: 4]
			: cls_code[PARTNER * 4 +: 4];
		assign link.cls_own = cls_done[ch];
		assign link.alloc_15w5 = alloc_15w5[ch];
		assign link.diag_single = diag_mode[ch] & cls_enable[ch] & ~cls_enable[PARTNER];
		assign pg_ready[ch] = chan_on[ch] & (s_q.power_good_flags[ch] | pg_below_thr[ch]);

		chan_discovery u_chan (
			.core_clk(core_clk),
			.sys_rst(sys_rst),
			.link(link)
		);

		assign disc_all[ch] = link.disc;
		assign class_done_event[ch] = link.cls_event;
		assign assigned_class[ch * 4 +: 4] = link.assigned;
	end

	////////////////////////////////////////////////////////////////////////////////
	// power state and command port
	assign power_byte = {s_q.power_good_flags, s_q.channel_on_flags};

	always_comb
	begin
		s_d = s_q;
		for (int i = 0; i < pse_regs_pkg::NUM_CH; i++)
		begin
			s_d.channel_on_flags[i] = chan_on[i];
			if (pair_single_sig[i / 2])
				s_d.power_good_flags[i] = chan_on[i] & (s_q.power_good_flags[i]
					| (pg_ready[i] & pg_ready[i ^ 1]));
			else
				s_d.power_good_flags[i] = pg_ready[i];
		end
		s_d.rd_valid = cmd_valid & ~cmd_write;
		s_d.cmd_hit = 1'b0;
		if (cmd_valid && (cmd_code >= pse_regs_pkg::CMD_DISC_FIRST)
			&& (cmd_code <= pse_regs_pkg::CMD_POWER_STATE))
			s_d.cmd_hit = 1'b1;
		if (cmd_valid && !cmd_write)
		begin
			if (cmd_code == pse_regs_pkg::CMD_POWER_STATE)
				s_d.rd_data = power_byte;
			else if ((cmd_code >= pse_regs_pkg::CMD_DISC_FIRST)
				&& (cmd_code <= pse_regs_pkg::CMD_DISC_LAST))
				s_d.rd_data = disc_all[cmd_code[1:0]];
			else
				s_d.rd_data = pse_regs_pkg::UNMAPPED_READ;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_q.power_good_flags <= pse_regs_pkg::POWER_FLAGS_RESET;
			s_q.channel_on_flags <= pse_regs_pkg::POWER_FLAGS_RESET;
			s_q.rd_data <= pse_regs_pkg::READ_DATA_RESET;
			s_q.rd_valid <= 1'b0;
			s_q.cmd_hit <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign rd_data = s_q.rd_data;
	assign rd_valid = s_q.rd_valid;
	assign cmd_hit = s_q.cmd_hit;

	////////////////////////////////////////////////////////////////////////////////
	// report deadline watch for pair 0-1
	logic pend_q;
	logic [3:0] pend_cls_q;
	logic [pse_regs_pkg::WAIT_W-1:0] wait_q;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pend_q <= 1'b0;
			pend_cls_q <= pse_regs_pkg::CLS_UNKNOWN;
			wait_q <= '0;
		end
		else if (cls_done[0] && pair_single_sig[0] && !cls_done[1])
		begin
			pend_q <= 1'b1;
			pend_cls_q <= cls_code[3:0];
			wait_q <= '0;
		end
		else if (pend_q && ((disc_all[1][7:4] == pend_cls_q) || !chan_on[1] || cls_done[1]))
			pend_q <= 1'b0;
		else if (pend_q)
			wait_q <= wait_q + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	report_deadline_a: assert property (pend_q |-> 32'(wait_q) < REPORT_LIMIT_CYC)
		else $error("class report too late");
	pair_event_a: assert property (cls_done[0] && pair_single_sig[0] && !cls_done[1]
		|=> class_done_event[0] && !class_done_event[1]) else $error("event on partner");
	dual_own_a: assert property (cls_done[1] && !pair_single_sig[0] && !cls_done[0]
		&& !diag_mode[1] && !$rose(chan_on[1]) && !$fell(chan_on[1])
		|=> disc_all[1][7:4] == $past(cls_code[7:4])) else $error("own class lost");
	disc_read_a: assert property (cmd_valid && !cmd_write && cmd_code == 8'h0E
		|=> rd_valid && cmd_hit && rd_data == $past(disc_all[2])) else $error("bad read");
	power_read_a: assert property (cmd_valid && !cmd_write
		&& cmd_code == pse_regs_pkg::CMD_POWER_STATE
		|=> rd_data == $past(power_byte) && rd_data[3:0] == $past(s_q.channel_on_flags))
		else $error("bad power byte");
	off_clears_a: assert property (!chan_on[1] |=> !power_byte[1] && !power_byte[5])
		else $error("power bits kept");
	pg_latch_a: assert property (chan_on[0] && pg_below_thr[0] && !pair_single_sig[0]
		##1 chan_on[0] [*3] |-> power_byte[4]) else $error("power good lost");
	single_pg_a: assert property (pair_single_sig[1] && !chan_on[3] && !power_byte[6]
		|=> !power_byte[6]) else $error("early power good");
	write_ignored_a: assert property (cmd_valid && cmd_write
		|=> !rd_valid && $stable(rd_data)) else $error("write had effect");
	unmapped_read_a: assert property (cmd_valid && !cmd_write
		&& (cmd_code < pse_regs_pkg::CMD_DISC_FIRST || cmd_code > pse_regs_pkg::CMD_POWER_STATE)
		|=> rd_valid && !cmd_hit && rd_data == pse_regs_pkg::UNMAPPED_READ)
		else $error("unmapped read answered");
	on_follow_a: assert property (1'b1 |=> power_byte[3:0] == $past(chan_on))
		else $error("on flags wrong");

	both_on_c: cover property (power_byte == 8'h33);
	pair_class_c: cover property (cls_done[0] && pair_single_sig[0] ##1 class_done_event[0]);
	fet_fault_c: cover property (det_done[1] && det_code[7:4] == pse_regs_pkg::DET_FET_FAULT);
	valid_read_c: cover property (rd_valid && rd_data[3:0] == pse_regs_pkg::DET_VALID);
endmodule // pse_discovery_power_status_regs

// ### tb/host_cmd_model.sv
`timescale 1ns/10ps
module host_cmd_model (
	input wire logic core_clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic cmd_hit
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'hFF;
	end
	////////////////////////////////////////////////////////////////
	// one strobe per command, answer taken one cycle later
	task automatic access(input logic wr, input logic [7:0] code, output logic [7:0] d,
		output logic v, output logic h);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = code;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		cmd_write = ~wr;
		cmd_code = ~code;
		d = rd_data;
		v = rd_valid;
		h = cmd_hit;
	endtask
endmodule // host_cmd_model

// ### tb/test_pse_discovery_power_status_regs.sv
`timescale 1ns/10ps
module test_pse_discovery_power_status_regs;
	logic core_clk, sys_rst;
	logic [3:0] chan_on, pg_below_thr, det_done, cls_done, alloc_15w5, diag_mode, cls_enable;
	logic [15:0] det_code, cls_code;
	logic [1:0] pair_single_sig;
	logic cmd_valid, cmd_write, rd_valid, cmd_hit;
	logic [7:0] cmd_code, rd_data;
	logic [3:0] class_done_event;
	logic [15:0] assigned_class;
	int n_errors, n_tests;
	pse_discovery_power_status_regs #(.REPORT_LIMIT_CYC(16)) dut_u (.core_clk, .sys_rst,
		.chan_on, .pg_below_thr, .det_done, .det_code, .cls_done, .cls_code,
		.pair_single_sig, .alloc_15w5, .diag_mode, .cls_enable, .cmd_valid, .cmd_write,
		.cmd_code, .rd_data, .rd_valid, .cmd_hit, .class_done_event, .assigned_class);
	host_cmd_model host_u (.core_clk, .cmd_valid, .cmd_write, .cmd_code, .rd_data,
		.rd_valid, .cmd_hit);
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] code, input logic [7:0] exp);
		logic [7:0] d;
		logic v, h, hit;
		hit = code >= pse_regs_pkg::CMD_DISC_FIRST && code <= pse_regs_pkg::CMD_POWER_STATE;
		host_u.access(1'b0, code, d, v, h);
		chk("read", {6'h00, exp, 1'b1, hit}, {6'h00, d, v, h});
	endtask
	task automatic cls_ev(input int ch, input logic [3:0] c, input logic [3:0] ev);
		@(negedge core_clk);
		cls_code[ch*4 +: 4] = c;
		cls_done[ch] = 1'b1;
		@(negedge core_clk);
		cls_done = 4'h0;
		chk("class_done_event", {12'h000, ev}, {12'h000, class_done_event});
	endtask
	task automatic det_ev(input int ch, input logic [3:0] c);
		@(negedge core_clk);
		det_code[ch*4 +: 4] = c;
		det_done[ch] = 1'b1;
		@(negedge core_clk);
		det_done = 4'h0;
	endtask
	task automatic set_on(input logic [3:0] on);
		chan_on = on;
		repeat (2) @(negedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		for (int c = 8'h0B; c <= 8'h11; c++) rd(c[7:0], 8'h00);
	endtask
	task automatic t_detect;
		logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hE};
		foreach (codes[i])
		begin
			det_ev(2, codes[i]);
			rd(8'h0E, {4'h0, codes[i]});
		end
	endtask
	task automatic t_class;
		for (int i = 0; i < 16; i++)
		begin
			cls_ev(3, i[3:0], 4'h8);
			rd(8'h0F, {i[3:0], 4'h0});
		end
	endtask
	task automatic t_pair;
		pair_single_sig = 2'h1;
		det_ev(0, 4'h4);
		cls_ev(0, 4'h8, 4'h1);
		rd(8'h0C, 8'h84);
		rd(8'h0D, 8'h80);
		pair_single_sig = 2'h0;
		cls_ev(1, 4'hD, 4'h2);
		rd(8'h0D, 8'hD0);
		rd(8'h0C, 8'h84);
	endtask
	task automatic t_power;
		cls_ev(1, 4'h6, 4'h2);
		alloc_15w5 = 4'h1;
		pg_below_thr = 4'h1;
		set_on(4'h3);
		rd(8'h0C, 8'hC4);
		rd(8'h0D, 8'h60);
		chk("assigned_class", 16'h003C, assigned_class);
		rd(8'h10, 8'h13);
		pg_below_thr = 4'h0;
		rd(8'h10, 8'h13);
		set_on(4'h2);
		rd(8'h0C, 8'h00);
		rd(8'h10, 8'h02);
		chk("assigned_class", 16'h0030, assigned_class);
		set_on(4'h0);
		alloc_15w5 = 4'h0;
	endtask
	task automatic t_diag;
		pair_single_sig = 2'h2;
		diag_mode = 4'h4;
		cls_enable = 4'h4;
		cls_ev(2, 4'hB, 4'h4);
		rd(8'h0E, 8'hDE);
		diag_mode = 4'h0;
		cls_enable = 4'hF;
		pair_single_sig = 2'h0;
	endtask
	task automatic t_write;
		logic [7:0] d;
		logic v, h;
		host_u.access(1'b1, 8'h0E, d, v, h);
		chk("write answer", 16'hDE01, {d, 6'h00, v, h});
		host_u.access(1'b1, 8'h10, d, v, h);
		chk("write answer", 16'hDE01, {d, 6'h00, v, h});
		rd(8'h0E, 8'hDE);
		rd(8'h0E, 8'hDE);
	endtask
	task automatic t_pg_pair;
		pair_single_sig = 2'h1;
		pg_below_thr = 4'h3;
		set_on(4'h1);
		rd(8'h10, 8'h01);
		set_on(4'h3);
		rd(8'h10, 8'h33);
		set_on(4'h0);
		rd(8'h10, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	// run
	task automatic test_done;
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		{chan_on, pg_below_thr, det_done, cls_done, alloc_15w5, diag_mode} = 24'h000000;
		{det_code, cls_code, pair_single_sig} = 34'h0;
		cls_enable = 4'hF;
		n_errors = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		t_reset();
		t_detect();
		t_class();
		t_pair();
		t_power();
		t_diag();
		t_write();
		t_pg_pair();
		test_done();
	end
endmodule // test_pse_discovery_power_status_regs
